// File: rtl/swpg_power_ctrl.sv
// Sleep mode sequencing, power-domain gating, wake-source evaluation and slow timer
`timescale 1ns/1ns
module swpg_power_ctrl import swpg_pkg::*; (
    input wire logic core_clk, // 50 MHz system clock
    input wire logic arst_n, // Power-up reset, active low
    input wire logic soft_rst, // System reset pulse, timer unaffected
    input wire logic slow_clk, // Slow low-power clock pin
    input wire logic sleep_req, // Pulse: enter sleep_mode
    input wire logic [2:0] sleep_mode, // Requested sleep mode
    input wire logic wake_req, // Pulse: software wake from modem sleep
    input wire logic [DOM_N-1:0] force_domain_on, // Per-domain force on
    input wire logic [DOM_N-1:0] force_domain_off, // Per-domain force off
    input wire logic [WK_N-1:0] wake_source_mask, // Wake-enable bitmap
    input wire logic [4:0] single_pad_select, // Pad watched by single-pad wake
    input wire logic single_pad_polarity, // 1 wakes on high level
    input wire logic [PAD_N-1:0] pad_group_mask, // Pads of the group wake
    input wire logic pad_group_polarity, // 1 any high, 0 all low
    input wire logic [PAD_N-1:0] rtc_pad, // Always-on pads
    input wire logic gpio_wake, // Low-power GPIO wake pin
    input wire logic sdio_cmd, // Pulse: SDIO command received
    input wire logic wireless_evt, // Pulse: wireless wake event
    input wire logic bt_evt, // Pulse: short-range radio wake event
    input wire logic [1:0] uart_rx, // UART receive pins
    input wire logic [UART_CNT_W-1:0] uart0_thresh, // UART0 pulse threshold
    input wire logic [UART_CNT_W-1:0] uart1_thresh, // UART1 pulse threshold
    input wire logic touch_evt, // Pulse: touch wake
    input wire logic ulp_evt, // Pulse: co-processor wake
    input wire logic [TIMER_W-1:0] timer_target, // Timer wake count
    input wire logic [PERIOD_W-1:0] touch_period, // Touch trigger period, 0 off
    input wire logic [PERIOD_W-1:0] ulp_period, // Co-processor trigger period, 0 off
    input wire logic [PERIOD_W-1:0] keepalive_period, // Radio keep-alive interval, 0 off
    output logic [DOM_N-1:0] domain_pwr, // Power enable per gated domain
    output logic core_always_on, // Always-on domain power
    output logic [2:0] power_mode, // Current mode
    output logic cpu_stall, // Processors stalled
    output logic dig_clk_gate, // Digital core clock gated
    output logic bb_clk_gate, // Baseband clock gated
    output logic rtc_low_volt, // Core supply lowered
    output logic [TIMER_W-1:0] timer_value, // Slow timer count
    output logic wake_pulse, // One-cycle wake event
    output logic [WK_N-1:0] wake_cause, // Sources that caused the last wake
    output logic touch_trig, // Periodic touch trigger pulse
    output logic ulp_trig // Periodic co-processor trigger pulse
);
    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [SYNC_W-1:0] meta_q, sync_q;
    logic [2:0] prev_q;
    logic [PAD_N-1:0] pad_s;
    logic gpio_s, tick, uart0_rise, uart1_rise;

    // Reset released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins pass two flops; edge history taken from the second only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= 3'h0;
        end else begin
            meta_q <= {rtc_pad, gpio_wake, uart_rx, slow_clk};
            sync_q <= meta_q;
            prev_q <= sync_q[2:0];
        end
    end
    assign pad_s = sync_q[21:4];
    assign gpio_s = sync_q[3];
    assign tick = sync_q[0] & ~prev_q[0];
    assign uart0_rise = sync_q[1] & ~prev_q[1];
    assign uart1_rise = sync_q[2] & ~prev_q[2];

    // ---------------------------------------------------------------
    // Slow timer
    // ---------------------------------------------------------------
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic timer_hit_q, timer_hit_d;

    // Counts slow edges; soft reset and sleep never touch it
    always_comb begin
        timer_d = timer_q + {{(TIMER_W-1){1'b0}}, tick};
        timer_hit_d = (timer_q >= timer_target);
    end

    // Only the power-up reset clears the count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= '0;
            timer_hit_q <= 1'b0;
        end else begin
            timer_q <= timer_d;
            timer_hit_q <= timer_hit_d;
        end
    end

    // ---------------------------------------------------------------
    // Periodic triggers: touch, co-processor, radio keep-alive
    // ---------------------------------------------------------------
    swpg_mode_e mode_q, mode_d;
    logic [PER_N-1:0][PERIOD_W-1:0] per_cnt_q, per_cnt_d;
    logic [PER_N-1:0][PERIOD_W-1:0] period;
    logic [PER_N-1:0] per_run, per_fire_q, per_fire_d;
    logic radio_wake_en;

    assign period = {keepalive_period, ulp_period, touch_period};
    assign radio_wake_en = |(wake_source_mask & WK_RADIO);
    // Keep-alive only runs while light sleep holds a radio connection
    assign per_run = {(mode_q == MODE_LIGHT) && radio_wake_en, 2'b11};

    // Each counter fires once per period of slow ticks
    always_comb begin
        for (int i = 0; i < PER_N; i++) begin
            per_cnt_d[i] = per_cnt_q[i];
            per_fire_d[i] = 1'b0;
            if (!per_run[i] || period[i] == '0) begin
                per_cnt_d[i] = '0;
            end else if (tick) begin
                if (per_cnt_q[i] >= period[i] - 16'h1) begin
                    per_cnt_d[i] = '0;
                    per_fire_d[i] = 1'b1;
                end else begin
                    per_cnt_d[i] = per_cnt_q[i] + 16'h1;
                end
            end
        end
    end

    // Trigger counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_q <= '0;
            per_fire_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_d;
            per_fire_q <= per_fire_d;
        end
    end

    // ---------------------------------------------------------------
    // UART pulse counters
    // ---------------------------------------------------------------
    logic [UART_CNT_W-1:0] u0_cnt_q, u0_cnt_d, u1_cnt_q, u1_cnt_d;

    // Count only while asleep so stale traffic cannot cause a wake
    always_comb begin
        u0_cnt_d = u0_cnt_q;
        u1_cnt_d = u1_cnt_q;
        if (mode_q == MODE_ACTIVE) begin
            u0_cnt_d = '0;
            u1_cnt_d = '0;
        end else begin
            if (uart0_rise && u0_cnt_q != '1) begin
                u0_cnt_d = u0_cnt_q + 10'h1;
            end
            if (uart1_rise && u1_cnt_q != '1) begin
                u1_cnt_d = u1_cnt_q + 10'h1;
            end
        end
    end

    // Pulse counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            u0_cnt_q <= '0;
            u1_cnt_q <= '0;
        end else begin
            u0_cnt_q <= u0_cnt_d;
            u1_cnt_q <= u1_cnt_d;
        end
    end

    // ---------------------------------------------------------------
    // Wake-source evaluation
    // ---------------------------------------------------------------
    logic [WK_N-1:0] src, allowed, wake_hits;
    logic pad_lvl, group_any_hi, group_all_lo;

    // Out-of-range pad selection never wakes
    assign pad_lvl = (single_pad_select < 5'(PAD_N)) ? pad_s[single_pad_select] : ~single_pad_polarity;
    assign group_any_hi = |(pad_s & pad_group_mask);
    assign group_all_lo = (pad_group_mask != '0) && ~|(pad_s & pad_group_mask);

    // Raw source levels, one bit per bitmap position
    always_comb begin
        src = '0;
        src[WK_PAD] = (pad_lvl == single_pad_polarity);
        src[WK_GROUP] = pad_group_polarity ? group_any_hi : group_all_lo;
        src[WK_GPIO] = gpio_s;
        src[WK_TIMER] = timer_hit_q;
        src[WK_SDIO] = sdio_cmd;
        src[WK_WIRELESS] = wireless_evt | per_fire_q[PER_KEEP];
        src[WK_UART0] = (u0_cnt_q > uart0_thresh);
        src[WK_UART1] = (u1_cnt_q > uart1_thresh);
        src[WK_TOUCH] = touch_evt;
        src[WK_ULP] = ulp_evt;
        src[WK_BT] = bt_evt | (per_fire_q[PER_KEEP] & wake_source_mask[WK_BT]);
        unique case (mode_q)
            MODE_DEEP: allowed = WK_OK_DEEP;
            MODE_HIBER: allowed = WK_OK_HIBER;
            MODE_ACTIVE: allowed = '0;
            default: allowed = WK_OK_LIGHT;
        endcase
        wake_hits = src & wake_source_mask & allowed;
    end

    // ---------------------------------------------------------------
    // Mode state machine and registered outputs
    // ---------------------------------------------------------------
    logic [DOM_N-1:0] pwr_q, pwr_d, dflt;
    logic wake_q, wake_d, stall_q, stall_d, gate_q, gate_d, bb_q, bb_d, lowv_q, lowv_d;
    logic [WK_N-1:0] cause_q, cause_d;

    // Next mode, then power and clock controls derived from it
    always_comb begin
        mode_d = mode_q;
        wake_d = 1'b0;
        cause_d = cause_q;
        if (mode_q == MODE_ACTIVE) begin
            if (sleep_req && sleep_mode >= 3'(MODE_MODEM) && sleep_mode <= 3'(MODE_HIBER)) begin
                mode_d = swpg_mode_e'(sleep_mode);
            end
        end else if (wake_hits != '0 || (mode_q == MODE_MODEM && wake_req)) begin
            mode_d = MODE_ACTIVE;
            wake_d = 1'b1;
            cause_d = wake_hits;
        end
        if (soft_rst) begin
            mode_d = MODE_ACTIVE;
            wake_d = 1'b0;
        end
        unique case (mode_d)
            MODE_ACTIVE: dflt = PWR_ACTIVE;
            MODE_MODEM: dflt = PWR_MODEM;
            MODE_LIGHT: dflt = PWR_LIGHT;
            MODE_DEEP: dflt = PWR_DEEP;
            MODE_HIBER: dflt = PWR_HIBER;
            default: dflt = PWR_ACTIVE;
        endcase
        // Independent per-bit override; force on beats force off
        pwr_d = (dflt & ~force_domain_off) | force_domain_on;
        // Nested domains cannot outlive the digital core
        if (!pwr_d[DOM_DIG_CORE]) begin
            pwr_d = pwr_d & ~DOM_NESTED;
        end
        stall_d = (mode_d != MODE_ACTIVE) && (mode_d != MODE_MODEM);
        gate_d = stall_d;
        bb_d = (mode_d != MODE_ACTIVE);
        lowv_d = (mode_d == MODE_DEEP) || (mode_d == MODE_HIBER);
    end

    // Reset lands in active mode with every domain on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_ACTIVE;
            pwr_q <= PWR_ACTIVE;
            wake_q <= 1'b0;
            cause_q <= '0;
            stall_q <= 1'b0;
            gate_q <= 1'b0;
            bb_q <= 1'b0;
            lowv_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            pwr_q <= pwr_d;
            wake_q <= wake_d;
            cause_q <= cause_d;
            stall_q <= stall_d;
            gate_q <= gate_d;
            bb_q <= bb_d;
            lowv_q <= lowv_d;
        end
    end

    // Output drive straight from flops; always-on domain has no override input
    logic aon_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aon_q <= 1'b1;
        end else begin
            aon_q <= 1'b1;
        end
    end
    assign core_always_on = aon_q;
    assign domain_pwr = pwr_q;
    assign power_mode = mode_q;
    assign cpu_stall = stall_q;
    assign dig_clk_gate = gate_q;
    assign bb_clk_gate = bb_q;
    assign rtc_low_volt = lowv_q;
    assign timer_value = timer_q;
    assign wake_pulse = wake_q;
    assign wake_cause = cause_q;
    assign touch_trig = per_fire_q[PER_TOUCH];
    assign ulp_trig = per_fire_q[PER_ULP];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_slow_tick;
        tick;
    endsequence
    sequence s_one_more;
        ##1 timer_q == $past(timer_q) + 48'h1;
    endsequence

    a_core_stays_on: assert property (@(posedge core_clk) disable iff (!rst_n) core_always_on)
        else $error("Always-on domain lost power");
    a_force_on_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        force_domain_on[DOM_SLOW_MEM] |=> domain_pwr[DOM_SLOW_MEM])
        else $error("Forced-on domain not powered");
    a_force_off_acts: assert property (@(posedge core_clk) disable iff (!rst_n)
        force_domain_off[DOM_PERIPH] && !force_domain_on[DOM_PERIPH] |=> !domain_pwr[DOM_PERIPH])
        else $error("Forced-off domain still powered");
    a_nested_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !domain_pwr[DOM_DIG_CORE] |-> (domain_pwr & DOM_NESTED) == '0)
        else $error("Nested domain powered without digital core");
    a_reset_active: assert property (@(posedge core_clk) disable iff (!arst_n)
        rst_n && !$past(rst_n) |-> power_mode == 3'(MODE_ACTIVE) && domain_pwr == PWR_ACTIVE)
        else $error("Not active after reset");
    a_light_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
        power_mode == 3'(MODE_LIGHT) && force_domain_on == '0 && $stable(power_mode)
        |-> cpu_stall && dig_clk_gate && domain_pwr[DOM_PLL] == 1'b0 && domain_pwr[DOM_RADIO] == 1'b0)
        else $error("Light sleep left clocks running");
    a_hiber_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode_q == MODE_HIBER && wake_d |=> (wake_cause & ~WK_OK_HIBER) == '0 && power_mode == 3'(MODE_ACTIVE))
        else $error("Illegal hibernation wake");
    a_timer_counts: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_slow_tick |-> s_one_more)
        else $error("Timer missed a slow tick");
endmodule // swpg_power_ctrl

// File: inc/swpg_pkg.sv
// Package of constants and types for the sleep, wake-up and power-gating controller
package swpg_pkg;
    // ---------------------------------------------------------------
    // Gated power domains
    // ---------------------------------------------------------------
    localparam int DOM_N = 14;
    localparam int DOM_PERIPH = 0;
    localparam int DOM_SLOW_MEM = 1;
    localparam int DOM_FAST_MEM = 2;
    localparam int DOM_DIG_CORE = 3;
    localparam int DOM_WIRELESS = 4;
    localparam int DOM_ROM = 5;
    localparam int DOM_SRAM0 = 6;
    localparam int SRAM_BANKS = 4;
    localparam int DOM_XTAL = 10;
    localparam int DOM_PLL = 11;
    localparam int DOM_OSC8M = 12;
    localparam int DOM_RADIO = 13;
    // Domains that live inside the digital core
    localparam logic [DOM_N-1:0] DOM_NESTED = 14'h03f0;
    // Default power per mode, before software overrides
    localparam logic [DOM_N-1:0] PWR_ACTIVE = 14'h3fff;
    localparam logic [DOM_N-1:0] PWR_MODEM = 14'h1fef;
    localparam logic [DOM_N-1:0] PWR_LIGHT = 14'h03ef;
    localparam logic [DOM_N-1:0] PWR_DEEP = 14'h0001;
    localparam logic [DOM_N-1:0] PWR_HIBER = 14'h0000;

    // ---------------------------------------------------------------
    // Wake sources (bit positions of the wake-enable bitmap)
    // ---------------------------------------------------------------
    localparam int WK_N = 11;
    localparam int WK_PAD = 0;
    localparam int WK_GROUP = 1;
    localparam int WK_GPIO = 2;
    localparam int WK_TIMER = 3;
    localparam int WK_SDIO = 4;
    localparam int WK_WIRELESS = 5;
    localparam int WK_UART0 = 6;
    localparam int WK_UART1 = 7;
    localparam int WK_TOUCH = 8;
    localparam int WK_ULP = 9;
    localparam int WK_BT = 10;
    localparam logic [WK_N-1:0] WK_OK_LIGHT = 11'h7ff;
    localparam logic [WK_N-1:0] WK_OK_DEEP = 11'h30f;
    localparam logic [WK_N-1:0] WK_OK_HIBER = 11'h00a;
    localparam logic [WK_N-1:0] WK_RADIO = 11'h420;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int PAD_N = 18;
    localparam int TIMER_W = 48;
    localparam int UART_CNT_W = 10;
    localparam int PERIOD_W = 16;
    localparam int PER_N = 3;
    localparam int PER_TOUCH = 0;
    localparam int PER_ULP = 1;
    localparam int PER_KEEP = 2;
    localparam int SYNC_W = 22;

    // ---------------------------------------------------------------
    // Power modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_MODEM = 3'b001,
        MODE_LIGHT = 3'b010,
        MODE_DEEP = 3'b011,
        MODE_HIBER = 3'b100
    } swpg_mode_e;
endpackage

// File: tb/tb_top.sv
// Self-checking testbench for the sleep, wake-up and power-gating controller
`timescale 1ns/1ns
module tb_top;
    import swpg_pkg::*;
    logic core_clk, arst_n, soft_rst, slow_clk, slow_run, sleep_req, wake_req;
    logic [2:0] sleep_mode, power_mode;
    logic [DOM_N-1:0] force_domain_on, force_domain_off, domain_pwr;
    logic [WK_N-1:0] wake_source_mask, wake_cause;
    logic [4:0] single_pad_select;
    logic single_pad_polarity, pad_group_polarity, gpio_wake, sdio_cmd, wireless_evt, bt_evt, touch_evt, ulp_evt;
    logic [PAD_N-1:0] pad_group_mask, rtc_pad;
    logic [1:0] uart_rx;
    logic [UART_CNT_W-1:0] uart0_thresh, uart1_thresh;
    logic [TIMER_W-1:0] timer_target, timer_value, t0;
    logic [PERIOD_W-1:0] touch_period, ulp_period, keepalive_period;
    logic core_always_on, cpu_stall, dig_clk_gate, bb_clk_gate, rtc_low_volt, wake_pulse, touch_trig, ulp_trig;
    int n_errors = 0;
    int n_tests = 0;
    int n_tick, n_touch, n_ulp, k, m, u;

    swpg_power_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .soft_rst(soft_rst), .slow_clk(slow_clk),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_req(wake_req), .force_domain_on(force_domain_on),
        .force_domain_off(force_domain_off), .wake_source_mask(wake_source_mask),
        .single_pad_select(single_pad_select), .single_pad_polarity(single_pad_polarity),
        .pad_group_mask(pad_group_mask), .pad_group_polarity(pad_group_polarity), .rtc_pad(rtc_pad),
        .gpio_wake(gpio_wake), .sdio_cmd(sdio_cmd), .wireless_evt(wireless_evt), .bt_evt(bt_evt),
        .uart_rx(uart_rx), .uart0_thresh(uart0_thresh), .uart1_thresh(uart1_thresh), .touch_evt(touch_evt),
        .ulp_evt(ulp_evt), .timer_target(timer_target), .touch_period(touch_period), .ulp_period(ulp_period),
        .keepalive_period(keepalive_period), .domain_pwr(domain_pwr), .core_always_on(core_always_on),
        .power_mode(power_mode), .cpu_stall(cpu_stall), .dig_clk_gate(dig_clk_gate), .bb_clk_gate(bb_clk_gate),
        .rtc_low_volt(rtc_low_volt), .timer_value(timer_value), .wake_pulse(wake_pulse), .wake_cause(wake_cause),
        .touch_trig(touch_trig), .ulp_trig(ulp_trig));

    // ---------------------------------------------------------------
    // Clocks, counters of observed events, watchdog
    // ---------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Slow clock toggles every third core cycle, well above the two-cycle minimum
    initial begin
        slow_clk = 1'b0;
        forever begin
            step(3);
            if (slow_run) slow_clk = ~slow_clk;
        end
    end
    always @(posedge slow_clk) n_tick++;
    // Trigger pulses stand one cycle, so each sampled high is one pulse
    always @(posedge core_clk) begin
        if (touch_trig === 1'b1) n_touch++;
        if (ulp_trig === 1'b1) n_ulp++;
    end
    // A hang is cut short well past the few hundred cycles the tests need
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end

    // ---------------------------------------------------------------
    // Reference model and shared tasks
    // ---------------------------------------------------------------
    function automatic logic [DOM_N-1:0] exp_pwr(input int md, input logic [DOM_N-1:0] on, input logic [DOM_N-1:0] off);
        logic [DOM_N-1:0] p;
        p = (md == 0) ? PWR_ACTIVE : (md == 1) ? PWR_MODEM : (md == 2) ? PWR_LIGHT : (md == 3) ? PWR_DEEP : PWR_HIBER;
        p = (p | on) & ~(off & ~on);
        if (!p[DOM_DIG_CORE]) p = p & ~DOM_NESTED;
        return p;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic chk(input logic [TIMER_W-1:0] got, input logic [TIMER_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic enter(input int md);
        sleep_mode = md[2:0];
        sleep_req = 1'b1;
        step(1);
        sleep_req = 1'b0;
        chk(power_mode, md);
        chk(domain_pwr, exp_pwr(md, force_domain_on, force_domain_off));
        chk(rtc_low_volt, md >= 3);
        chk(core_always_on, 1);
        chk(bb_clk_gate, md != 0);
        if (md <= 2) chk({cpu_stall, dig_clk_gate}, (md == 2) ? 2'b11 : 2'b00);
    endtask
    task automatic wait_wake(input logic [WK_N-1:0] cause);
        for (int i = 0; i < 60 && wake_pulse !== 1'b1; i++) step(1);
        chk(wake_pulse, 1);
        chk(wake_cause, cause);
        chk(domain_pwr, exp_pwr(0, force_domain_on, force_domain_off));
        chk(power_mode, 0);
        chk({cpu_stall, dig_clk_gate, bb_clk_gate, rtc_low_volt}, 4'h0);
        rtc_pad = '0;
        step(1);
        chk(wake_pulse, 0);
        step(4);
    endtask
    task automatic no_wake(input int n, input int md);
        repeat (n) begin
            step(1);
            chk(wake_pulse, 0);
        end
        chk(power_mode, md);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {arst_n, soft_rst, sleep_req, wake_req, gpio_wake, sdio_cmd, wireless_evt, bt_evt} = '0;
        {touch_evt, ulp_evt, single_pad_polarity, pad_group_polarity, uart_rx, single_pad_select} = '0;
        {force_domain_on, force_domain_off, wake_source_mask, pad_group_mask, rtc_pad} = '0;
        {touch_period, ulp_period, keepalive_period, uart0_thresh, uart1_thresh} = '0;
        sleep_mode = 3'h0;
        timer_target = '1;
        slow_run = 1'b1;
        void'($urandom(32'hf0f2));
        step(10);
        chk({power_mode, domain_pwr, core_always_on}, {3'h0, 14'h3fff, 1'b1});
        arst_n = 1'b1;
        step(5);
        // Every mode with random overrides: forbidden sources ignored, pad group wakes
        for (m = 1; m <= 4; m++) begin
            force_domain_on = 14'($urandom());
            force_domain_off = 14'($urandom());
            enter(m);
            if (m >= 3) begin
                wake_source_mask = (m == 3) ? 11'h010 : 11'h114;
                {sdio_cmd, gpio_wake, touch_evt} = 3'b111;
                no_wake(6, m);
                {sdio_cmd, gpio_wake, touch_evt} = 3'b000;
            end
            k = $urandom_range(17, 0);
            {wake_source_mask, pad_group_polarity} = {11'h002, 1'b1};
            pad_group_mask = 18'($urandom()) | (18'h1 << k);
            rtc_pad = 18'h1 << k;
            wait_wake(11'h002);
        end
        force_domain_off = '0;
        // Group polarity 0 needs every selected pad low; pads settle through the flops before sleep
        pad_group_polarity = 1'b0;
        rtc_pad = ~pad_group_mask | (18'h1 << k);
        // Software keeps both retention memories powered through deep sleep
        force_domain_on = (14'h1 << DOM_SLOW_MEM) | (14'h1 << DOM_FAST_MEM);
        step(3);
        enter(3);
        chk(domain_pwr[DOM_FAST_MEM:DOM_SLOW_MEM], 2'h3);
        no_wake(6, 3);
        rtc_pad = ~pad_group_mask;
        wait_wake(11'h002);
        // Single pad at the chosen level; the opposite level does nothing
        wake_source_mask = 11'h001;
        force_domain_on = '0;
        single_pad_select = 5'($urandom_range(17, 0));
        single_pad_polarity = 1'($urandom());
        rtc_pad = {PAD_N{~single_pad_polarity}};
        step(3);
        enter(3);
        no_wake(6, 3);
        rtc_pad[single_pad_select] = single_pad_polarity;
        wait_wake(11'h001);
        // Modem sleep left by software, light sleep by an SDIO command; pad source off so it cannot wake first
        wake_source_mask = '0;
        enter(1);
        wake_req = 1'b1;
        step(1);
        wake_req = 1'b0;
        wait_wake(11'h000);
        wake_source_mask = 11'h010;
        enter(2);
        sdio_cmd = 1'b1;
        step(1);
        sdio_cmd = 1'b0;
        wait_wake(11'h010);
        // Each UART wakes only on the pulse after its threshold count
        for (u = 0; u < 2; u++) begin
            uart0_thresh = 10'($urandom_range(5, 1));
            uart1_thresh = 10'($urandom_range(5, 1));
            wake_source_mask = 11'h040 << u;
            enter(2);
            repeat ((u == 0) ? uart0_thresh : uart1_thresh) begin
                uart_rx[u] = 1'b1;
                no_wake(3, 2);
                uart_rx[u] = 1'b0;
                no_wake(3, 2);
            end
            uart_rx[u] = 1'b1;
            step(1);
            uart_rx[u] = 1'b0;
            wait_wake(11'h040 << u);
        end
        // Keep-alive interval wakes light sleep as a radio event
        keepalive_period = 16'h0002;
        wake_source_mask = 11'h020;
        enter(2);
        wait_wake(11'h020);
        keepalive_period = '0;
        // Each same-clock event source wakes light sleep on its own bitmap bit
        for (k = 0; k < 4; k++) begin
            wake_source_mask = (k == 0) ? 11'h020 : 11'h080 << k;
            enter(2);
            {bt_evt, ulp_evt, touch_evt, wireless_evt} = 4'h1 << k;
            step(1);
            {bt_evt, ulp_evt, touch_evt, wireless_evt} = 4'h0;
            wait_wake(wake_source_mask);
        end
        // Timer survives soft reset; touch fires every tick, co-processor every other tick
        slow_run = 1'b0;
        step(10);
        {touch_period, ulp_period} = {16'h0001, 16'h0002};
        t0 = timer_value;
        soft_rst = 1'b1;
        step(1);
        soft_rst = 1'b0;
        step(1);
        chk(timer_value, t0);
        {n_tick, n_touch, n_ulp} = '0;
        slow_run = 1'b1;
        step(60);
        slow_run = 1'b0;
        step(10);
        chk(timer_value, t0 + n_tick);
        chk(n_touch, n_tick);
        chk(n_ulp, n_tick / 2);
        slow_run = 1'b1;
        // Timer wakes deep sleep at the programmed count
        timer_target = timer_value + 48'h2;
        wake_source_mask = 11'h008;
        enter(3);
        wait_wake(11'h008);
        complete_run();
    end
endmodule // tb_top
